// ### src/chan_ctrl_pkg.sv
// package: register map, field positions and types for the channel enable/polarity block
package chan_ctrl_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CHAN_ENABLE_POLARITY_OFS = 8'h20;
  localparam int BIT_CHAN_ENABLE = 0;
  localparam int BIT_CHAN_POLARITY = 1;
  localparam int BIT_COMPL_ENABLE = 2;
  localparam int BIT_COMPL_POLARITY = 3;
  localparam logic [3:0] ENABLE_REG_RESET = 4'h0;
  localparam logic [31:0] READ_IDLE = 32'h0000_0000;
  localparam logic [1:0] DIR_OUTPUT = 2'h0;
  localparam logic [1:0] DIR_INPUT_TI1 = 2'h1;
  localparam logic [1:0] LOCK_LEVEL_2 = 2'h2;
  localparam logic [1:0] LOCK_LEVEL_3 = 2'h3;
  localparam logic [1:0] EDGE_RISING = 2'h0;
  localparam logic [1:0] EDGE_FALLING = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic main_output_enable;
    logic offstate_idle_select;
    logic offstate_run_select;
    logic idle_state_main;
    logic idle_state_compl;
    logic [1:0] lock_level;
  } brk_ctrl_t;

  typedef struct packed {
    logic level;
    logic oe;
  } pin_drive_t;

  typedef struct packed {
    logic capture_enable;
    logic rise;
    logic fall;
    logic invert;
    logic reserved_cfg;
  } capture_ctrl_t;
endpackage : chan_ctrl_pkg

// ### src/channel_enable_polarity_ctrl.sv
// enable and polarity control for one capture/compare channel with complementary output
`timescale 1ns/1ps
// Operation
// R1 - The complementary output is active high when its polarity bit is 0 and active low when it is 1.
// R2 - Writes to the complementary polarity bit are ignored while lock level is 2 or 3 and the channel is an output.
// R3 - Complementary enable 0 keeps the complementary output inactive, 1 sends it to its pin, subject to the break bits.
// R4 - In output mode the main output is active high when the channel polarity bit is 0 and active low when it is 1.
// R5 - In input mode the two polarity bits pick rising (00), falling (01) or both (11) edges, 10 being reserved.
// R6 - The channel polarity bit cannot be changed when lock level is 2 or 3 and the channel is an output.
// R7 - In output mode channel enable 0 disables the main output and 1 sends it to its pin, subject to the break bits.
// R8 - In input mode the channel enable gates capture of the counter into the compare value register.
// R9 - The enable register resets to zero and its bits 31 to 4 are reserved and read as zero.
// R10 - Direction select 00 makes the channel an output, 01 an input on the first timer input, others are reserved.
// R11 - The input capture prescaler is reset whenever the channel enable is zero.
// R12 - With main output enable set and the main output enabled, it equals the reference xor channel polarity.
// R13 - With only the complementary output enabled, it equals the reference xor complementary polarity.
// R14 - Locked polarity bits keep their value while the other bits of the same write are stored normally.
module channel_enable_polarity_ctrl (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire chan_ctrl_pkg::reg_req_t req_i,
  output chan_ctrl_pkg::reg_req_t req_echo_unused_o,
  output logic [31:0] rdata_o,
  input wire chan_ctrl_pkg::brk_ctrl_t brk_i,
  input wire logic [1:0] chan_direction_select_i,
  input wire logic compare_reference_i,
  input wire logic filtered_input_edge_i,
  output chan_ctrl_pkg::pin_drive_t main_compare_output_o,
  output chan_ctrl_pkg::pin_drive_t compl_compare_output_o,
  output chan_ctrl_pkg::capture_ctrl_t capture_o,
  output logic input_capture_prescale_clr_o,
  output logic capture_strobe_o
);
  import chan_ctrl_pkg::*;

  // one decoder for the polarity pair, so rise, fall and invert can never disagree
  function automatic logic code_is(input logic [1:0] code, input logic [1:0] want);
    return code == want;
  endfunction : code_is

  logic [3:0] enable_reg;
  logic [3:0] enable_next;
  logic [31:0] rdata_reg;
  logic [2:0] in_sync_reg;
  logic in_level_reg;
  logic in_agree;
  logic capture_strobe_reg;
  pin_drive_t main_reg;
  pin_drive_t compl_reg;
  pin_drive_t main_next;
  pin_drive_t compl_next;
  capture_ctrl_t capture_reg;
  logic is_output;
  logic is_input;
  logic locked;
  logic wr_hit;
  logic ce;
  logic cp;
  logic cne;
  logic cnp;

  // spare port, held at zero so it is never left undriven
  assign req_echo_unused_o = '0;

  assign ce = enable_reg[BIT_CHAN_ENABLE];
  assign cp = enable_reg[BIT_CHAN_POLARITY];
  assign cne = enable_reg[BIT_COMPL_ENABLE];
  assign cnp = enable_reg[BIT_COMPL_POLARITY];
  assign is_output = (chan_direction_select_i == DIR_OUTPUT); // R10
  assign is_input = (chan_direction_select_i == DIR_INPUT_TI1); // R10
  assign locked = is_output && (brk_i.lock_level == LOCK_LEVEL_2 || brk_i.lock_level == LOCK_LEVEL_3);
  assign wr_hit = req_i.wr && (req_i.addr == CHAN_ENABLE_POLARITY_OFS);

  // write path: polarity bits hold their value under lock, enables always write
  always_comb begin
    enable_next = enable_reg;
    if (wr_hit) begin
      enable_next[BIT_CHAN_ENABLE] = req_i.wdata[BIT_CHAN_ENABLE];
      enable_next[BIT_COMPL_ENABLE] = req_i.wdata[BIT_COMPL_ENABLE]; // R14
      if (!locked) begin
        enable_next[BIT_CHAN_POLARITY] = req_i.wdata[BIT_CHAN_POLARITY]; // R6
        enable_next[BIT_COMPL_POLARITY] = req_i.wdata[BIT_COMPL_POLARITY]; // R2
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_reg <= ENABLE_REG_RESET; // R9
    end else begin
      enable_reg <= enable_next;
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= READ_IDLE;
    end else if (req_i.rd && req_i.addr == CHAN_ENABLE_POLARITY_OFS) begin
      rdata_reg <= 32'(enable_reg); // R9
    end else begin
      rdata_reg <= READ_IDLE;
    end
  end
  assign rdata_o = rdata_reg;

  // output stage: main output enable high lets the enables drive, otherwise idle handling
  always_comb begin
    main_next = '0;
    compl_next = '0;
    if (is_output) begin
      if (brk_i.main_output_enable) begin
        if (ce && cne) begin
          // no dead-time here: complementary simply mirrors the inverted reference
          main_next = '{level: compare_reference_i ^ cp, oe: 1'b1}; // R4
          compl_next = '{level: ~compare_reference_i ^ cnp, oe: 1'b1}; // R1
        end else if (ce) begin
          main_next = '{level: compare_reference_i ^ cp, oe: 1'b1}; // R12 R7
          compl_next = '{level: cnp, oe: brk_i.offstate_run_select}; // R3
        end else if (cne) begin
          compl_next = '{level: compare_reference_i ^ cnp, oe: 1'b1}; // R13 R3
          main_next = '{level: cp, oe: brk_i.offstate_run_select}; // R7
        end
      end else if (brk_i.offstate_idle_select && (ce || cne)) begin
        main_next = '{level: brk_i.idle_state_main, oe: 1'b1};
        compl_next = '{level: brk_i.idle_state_compl, oe: 1'b1};
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      main_reg <= '0;
      compl_reg <= '0;
    end else begin
      main_reg <= main_next;
      compl_reg <= compl_next;
    end
  end
  assign main_compare_output_o = main_reg;
  assign compl_compare_output_o = compl_reg;

  // capture edge selection from the polarity pair in input mode
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      capture_reg <= '0;
    end else begin
      capture_reg.capture_enable <= is_input && ce; // R8
      capture_reg.rise <= is_input && (code_is({cnp, cp}, EDGE_RISING) || code_is({cnp, cp}, EDGE_BOTH)); // R5
      capture_reg.fall <= is_input && (code_is({cnp, cp}, EDGE_FALLING) || code_is({cnp, cp}, EDGE_BOTH)); // R5
      capture_reg.invert <= is_input && code_is({cnp, cp}, EDGE_FALLING); // R5
      capture_reg.reserved_cfg <= is_input && cnp && !cp; // R5
    end
  end
  assign capture_o = capture_reg;
  assign input_capture_prescale_clr_o = ~ce; // R11

  // the input pin is asynchronous, so a change counts only once stages two and three agree
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_sync_reg <= '0;
    end else begin
      in_sync_reg <= {in_sync_reg[1:0], filtered_input_edge_i};
    end
  end

  // accepted pin level moves only while stages two and three agree; reset matches the idle-low pin
  assign in_agree = (in_sync_reg[1] == in_sync_reg[2]);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_level_reg <= 1'b0;
    end else if (in_agree) begin
      in_level_reg <= in_sync_reg[2];
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      capture_strobe_reg <= 1'b0;
    end else begin
      capture_strobe_reg <= capture_reg.capture_enable && in_agree &&
        ((capture_reg.rise && in_sync_reg[2] && !in_level_reg) ||
         (capture_reg.fall && !in_sync_reg[2] && in_level_reg)); // R8
    end
  end
  assign capture_strobe_o = capture_strobe_reg;
endmodule : channel_enable_polarity_ctrl

// ### sim/channel_enable_polarity_ctrl_properties.sv
// checker: port-level properties of the channel enable/polarity block
`timescale 1ns/1ps
module chan_ctrl_props
  import chan_ctrl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire reg_req_t req_i,
  input wire logic [31:0] rdata_o,
  input wire brk_ctrl_t brk_i,
  input wire logic [1:0] chan_direction_select_i,
  input wire logic compare_reference_i,
  input wire pin_drive_t main_compare_output_o,
  input wire pin_drive_t compl_compare_output_o,
  input wire capture_ctrl_t capture_o,
  input wire logic input_capture_prescale_clr_o
);
  logic [3:0] sh_reg;
  wire out_mode = chan_direction_select_i == DIR_OUTPUT;
  wire in_mode = chan_direction_select_i == DIR_INPUT_TI1;
  // mirror of the enable register, so the output properties need no read-back
  always_ff @(posedge ref_clk_i or negedge nrst_i)
    if (!nrst_i) sh_reg <= ENABLE_REG_RESET;
    else if (req_i.wr && req_i.addr == CHAN_ENABLE_POLARITY_OFS) sh_reg <= out_mode && brk_i.lock_level[1]
      ? {sh_reg[3], req_i.wdata[2], sh_reg[1], req_i.wdata[0]} : req_i.wdata[3:0];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_read; req_i.rd && req_i.addr == CHAN_ENABLE_POLARITY_OFS; endsequence
  a_read_back: assert property (s_read |=> rdata_o == {28'h0, $past(sh_reg)}) else $error("readback");
  a_prescale_clr: assert property (s_read |=> input_capture_prescale_clr_o == !rdata_o[0]) else $error("clr");
  a_main_active: assert property (out_mode && brk_i.main_output_enable && sh_reg[0]
    |=> main_compare_output_o == {$past(compare_reference_i) ^ $past(sh_reg[1]), 1'h1}) else $error("main");
  a_compl_active: assert property (out_mode && brk_i.main_output_enable && !sh_reg[0] && sh_reg[2]
    |=> compl_compare_output_o == {$past(compare_reference_i) ^ $past(sh_reg[3]), 1'h1}) else $error("compl");
  a_off_idle: assert property (out_mode && !brk_i.main_output_enable && !brk_i.offstate_idle_select
    |=> !main_compare_output_o.oe && !compl_compare_output_o.oe) else $error("off");
  a_capture_gate: assert property (in_mode |=> capture_o.capture_enable == $past(sh_reg[0])) else $error("gate");
  a_edge_both: assert property (in_mode && sh_reg[3] && sh_reg[1] |=> capture_o.rise && capture_o.fall) else $error("both");
  a_edge_fall: assert property (in_mode && !sh_reg[3] && sh_reg[1]
    |=> !capture_o.rise && capture_o.fall && capture_o.invert) else $error("fall");
endmodule : chan_ctrl_props

// ### sim/edge_source_model.sv
// far-side source on the capture pin, rising 37 ns and falling 237 ns after each pulse rising edge, at a fixed phase to the timer clock
`timescale 1ns/1ps
module edge_source_model (
  input wire logic pulse_i,
  output logic pin_o = 1'b0
);
  always @(posedge pulse_i) begin pin_o <= #37 1'b1; pin_o <= #237 1'b0; end
endmodule : edge_source_model

// ### sim/channel_enable_polarity_ctrl_test.sv
// testbench: register access, output enables, lock and capture-edge scenarios
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; $display("FAIL %0t %h %h", $time, a, b); end end
module channel_enable_polarity_ctrl_test;
  import chan_ctrl_pkg::*;
  localparam logic [7:0] ENR = CHAN_ENABLE_POLARITY_OFS;
  localparam logic [3:0] CFG [4] = '{4'h0, 4'h1, 4'h3, 4'hB};
  localparam logic [3:0] EXP [4] = '{4'h4, 4'hC, 4'hB, 4'hE};
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, pulse = 1'b0, cref = 1'b0, pin, clr, strobe;
  logic [1:0] dir = DIR_OUTPUT;
  logic [31:0] rdata;
  reg_req_t req = '0;
  brk_ctrl_t brk = '0;
  pin_drive_t main_o, compl_o;
  capture_ctrl_t cap;
  int n_fail = 0, num_checks = 0, cnt;
  channel_enable_polarity_ctrl DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_i(req), .req_echo_unused_o(),
    .rdata_o(rdata), .brk_i(brk), .chan_direction_select_i(dir), .compare_reference_i(cref),
    .filtered_input_edge_i(pin), .main_compare_output_o(main_o), .compl_compare_output_o(compl_o),
    .capture_o(cap), .input_capture_prescale_clr_o(clr), .capture_strobe_o(strobe));
  edge_source_model src (.pulse_i(pulse), .pin_o(pin));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  // the compare reference keeps moving so polarity faults show at the pins
  always @(posedge ref_clk_i) cref <= ~cref;
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    req <= '{addr: a, wdata: w ? d : 32'h0, wr: w, rd: !w};
    @(posedge ref_clk_i);
    req <= '0;
    if (!w) #1 `CHK(rdata, d)
  endtask : access
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  initial begin
    repeat (12) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    access(1'b0, ENR, 32'h0);
    @(posedge ref_clk_i) brk.main_output_enable <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      access(1'b1, ENR, 32'(i));
      repeat (2) @(posedge ref_clk_i);
      #1 `CHK({main_o.oe, compl_o.oe}, {i[0], i[2]})
    end
    access(1'b0, 8'h24, 32'h0);
    for (int lv = 2; lv < 4; lv++) begin
      @(posedge ref_clk_i) brk.lock_level <= 2'(lv);
      access(1'b1, ENR, 32'h0);
      access(1'b0, ENR, 32'hA);
    end
    // lock only guards output mode, so every edge code must store here
    @(posedge ref_clk_i) dir <= DIR_INPUT_TI1;
    foreach (CFG[k]) begin
      access(1'b1, ENR, {28'h0, CFG[k]});
      access(1'b0, ENR, {28'h0, CFG[k]});
      `CHK({clr, cap.capture_enable, cap.rise, cap.fall, cap.invert}, {!EXP[k][3], EXP[k]})
      @(posedge ref_clk_i) pulse <= 1'b1;
      cnt = 0;
      repeat (24) begin @(posedge ref_clk_i); #1 cnt += int'(strobe); end
      pulse <= 1'b0;
      `CHK(cnt, EXP[k][3] ? int'(EXP[k][2]) + int'(EXP[k][1]) : 0)
    end
    results();
  end
endmodule : channel_enable_polarity_ctrl_test
bind channel_enable_polarity_ctrl chan_ctrl_props props (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_i(req_i),
  .rdata_o(rdata_o), .brk_i(brk_i), .chan_direction_select_i(chan_direction_select_i), .capture_o(capture_o),
  .compare_reference_i(compare_reference_i), .main_compare_output_o(main_compare_output_o),
  .compl_compare_output_o(compl_compare_output_o), .input_capture_prescale_clr_o(input_capture_prescale_clr_o));
